// ---- rtl/icf_top.sv ----
// interrupt gathering and cpu status flag logic
// assumes the core decodes ops and presents them for one cycle each
//
// Behaviour
// [R1] saved word: excess 15, saturate 14, block 13, ptr 8, page 0, bit1 zero
// [R2] load flags overwrites all status bits except the global block bit
// [R3] block bit set by block op and reset, cleared by unblock op
// [R4] block bit holds off maskable interrupts only, never the non-maskable one
// [R5] ptr select picks aux pointer zero or one, updated by listed ops
// [R6] direct address is page bit over seven instruction bits
// [R7] excess flag set on overflow, cleared by reset, branch or load flags
// [R8] saturate enable clamps overflowed accumulator; set, cleared, loaded
// [R9] direct save flags targets page one; indirect uses selected pointer
// [R10] save flags leaves all status bits unchanged
// [R11] both external requests detected on a falling pin edge
// [R12] each event sets its pending bit until software clears it; the nmi bit also clears itself when the cpu accepts it
// [R13] unmasked pending bit raises the cpu request; masked ones stay latched
// [R14] request with block clear pushes pc and vectors to word two
// [R15] taking any interrupt sets the block bit
// [R16] non-maskable bypasses mask and block; mask bit 15 does not mask it
// [R17] writing ones to pending clear clears those pending bits
// [R18] pending, mask, clear at bank zero, ports four, five, six
// [R19] pending bit positions of each interrupt source
// [R20] software keeps reserved bit 13 pending zero and masked
// [R21] software clears pending bits only through pending clear
// [R22] service routine reads pending, clears flag, then unblocks
// [R23] reset clears pending bits and sets all mask bits
// [R24] cpu request drops when the cpu takes the interrupt
`timescale 1ns/1ps
module icf_top (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   nonmask_irq_pin,
  input  wire logic                   external_irq_pin,
  input  wire logic                   tmr3_serial_irq,
  input  wire logic                   cap3_irq,
  input  wire logic                   cap2_irq,
  input  wire logic                   cap1_irq,
  input  wire logic                   cap0_irq,
  input  wire logic                   cmp1_irq,
  input  wire logic                   cmp0_irq,
  input  wire logic                   tmr2_irq,
  input  wire logic                   tmr1_irq,
  input  wire logic                   rx_irq,
  input  wire logic                   tx_irq,
  input  wire logic                   watchdog_irq,
  input  wire logic                   bitio_irq,
  input  wire icf_pkg::icf_op_e       op,
  input  wire logic                   op_ptr_value,
  input  wire logic                   op_page_value,
  input  wire logic [15:0]            load_word,
  input  wire logic [6:0]             instr_low,
  input  wire logic                   indirect,
  input  wire logic [7:0]             aux_ptr_zero,
  input  wire logic [7:0]             aux_ptr_one,
  input  wire logic                   acc_overflow,
  input  wire logic                   acc_overflow_neg,
  input  wire logic [31:0]            acc_raw,
  input  wire logic                   irq_accept,
  input  wire logic                   io_wr,
  input  wire logic                   io_rd,
  input  wire logic [3:0]             io_bank,
  input  wire logic [2:0]             io_port,
  input  wire logic [15:0]            io_wdata,
  output logic      [15:0]            io_rdata,
  output logic                        io_hit,
  output logic                        cpu_irq_request,
  output logic                        nmi_request,
  output logic                        take_irq,
  output logic      [11:0]            vector_addr,
  output logic      [15:0]            saved_flags,
  output logic      [7:0]             data_addr,
  output logic      [31:0]            acc_result,
  output logic                        ptr_select,
  output logic                        page_bit,
  output logic                        irq_global_block,
  output logic                        excess_flag,
  output logic                        saturate_enable
);
  import icf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin edges and event vector
  logic nmi_fall;
  logic ext_fall;
  icf_edge_sync u_nmi_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (nonmask_irq_pin),
    .fall  (nmi_fall)
  ); // see [R11]
  icf_edge_sync u_ext_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (external_irq_pin),
    .fall  (ext_fall)
  ); // see [R11]

  wire [15:0] events = {nmi_fall, ext_fall, 1'b0, tmr3_serial_irq,
                        cap3_irq, cap2_irq, cap1_irq, cap0_irq,
                        cmp1_irq, cmp0_irq, tmr2_irq, tmr1_irq,
                        rx_irq, tx_irq, watchdog_irq, bitio_irq}; // see [R19]

  ////////////////////////////////////////////////////////////////////////////
  // i/o register decode
  wire bank_hit = (io_bank == ICF_BANK_IRQ);
  wire sel_pend = bank_hit && (io_port == ICF_PORT_PEND); // see [R18]
  wire sel_mask = bank_hit && (io_port == ICF_PORT_MASK); // see [R18]
  wire sel_clr  = bank_hit && (io_port == ICF_PORT_CLR);  // see [R18]
  wire wr_pend  = io_wr && sel_pend;
  wire wr_mask  = io_wr && sel_mask;
  wire wr_clr   = io_wr && sel_clr;
  wire rd_any   = io_rd && (sel_pend || sel_mask);

  logic [15:0] pending_flags_ff;
  logic [15:0] mask_bits_ff;
  logic [15:0] nxt_pending;
  logic [15:0] nxt_mask;
  logic [15:0] io_rdata_ff;
  logic        io_hit_ff;
  logic        ptr_select_ff;
  logic        page_bit_ff;
  logic        irq_global_block_ff;
  logic        excess_flag_ff;
  logic        saturate_enable_ff;
  logic        served_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pending and mask bits
  // a direct write is honoured but events in the same cycle still win
  wire [15:0] pend_written = wr_pend ? io_wdata : pending_flags_ff;
  wire [15:0] pend_cleared = wr_clr ? (pend_written & ~io_wdata) : pend_written; // see [R17]
  // nmi bit is self-cleared on acceptance so one edge gives one entry
  wire [15:0] nmi_ack      = {(irq_accept && pending_flags_ff[ICF_NMI_BIT]), 15'h0000};
  assign nxt_pending = (pend_cleared & ~nmi_ack) | events; // see [R12]
  assign nxt_mask    = wr_mask ? io_wdata : mask_bits_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pending_flags_ff <= ICF_PEND_RST; // see [R23]
      mask_bits_ff     <= ICF_MASK_RST; // see [R23]
    end
    else
    begin
      pending_flags_ff <= nxt_pending;
      mask_bits_ff     <= nxt_mask;
    end
  end

  wire [15:0] rd_mux = sel_pend ? pending_flags_ff : mask_bits_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      io_rdata_ff <= 16'h0000;
      io_hit_ff   <= 1'b0;
    end
    else
    begin
      io_rdata_ff <= rd_any ? rd_mux : 16'h0000;
      io_hit_ff   <= rd_any;
    end
  end
  assign io_rdata = io_rdata_ff;
  assign io_hit   = io_hit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request to the cpu
  // mask bit 15 is ignored; the nmi has its own path
  wire        nmi_pend   = pending_flags_ff[ICF_NMI_BIT]; // see [R16]
  wire [14:0] unmasked   = pending_flags_ff[14:0] & ~mask_bits_ff[14:0]; // see [R13]
  wire        mask_req   = |unmasked;
  // request drops when the cpu takes it and stays low until unblock or until
  // no unmasked pending bit remains; a source still pending then asks again
  wire        served_set = irq_accept && take_irq && !nmi_pend; // see [R24]
  wire        served_clr = (op == ICF_OP_UNBLOCK) || !mask_req;
  wire        nxt_served = served_set ? 1'b1 : (served_clr ? 1'b0 : served_ff);
  assign cpu_irq_request = mask_req && !served_ff; // see [R13] see [R24]
  assign nmi_request     = nmi_pend; // see [R16]
  assign take_irq        = nmi_pend || (cpu_irq_request && !irq_global_block_ff); // see [R4]
  // the cpu pushes pc on irq_accept and jumps to the vector
  assign vector_addr     = ICF_VECTOR; // see [R14]
  wire   accept_ok       = irq_accept && take_irq;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      served_ff <= 1'b0;
    else
      served_ff <= nxt_served; // see [R24]
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word

  wire is_load = (op == ICF_OP_LOAD_FLAGS);
  wire ptr_upd = (op == ICF_OP_LOAD_PTR) || (op == ICF_OP_MODIFY_PTR) ||
                 (op == ICF_OP_INDIRECT); // see [R5]
  wire page_upd = (op == ICF_OP_LOAD_PAGE) || (op == ICF_OP_LOAD_PAGE_CONST); // see [R6]

  wire nxt_ptr  = is_load ? load_word[ICF_SV_PTR] :
                  ptr_upd ? op_ptr_value : ptr_select_ff; // see [R5]
  wire nxt_page = is_load ? load_word[ICF_SV_PAGE] :
                  page_upd ? op_page_value : page_bit_ff; // see [R6]
  // load flags never touches the block bit
  wire nxt_block = accept_ok ? 1'b1 :
                   (op == ICF_OP_BLOCK)   ? 1'b1 :
                   (op == ICF_OP_UNBLOCK) ? 1'b0 : irq_global_block_ff; // see [R2] see [R3] see [R15]
  // overflow in the same cycle as a clearing op wins
  wire nxt_excess = acc_overflow ? 1'b1 :
                    is_load ? load_word[ICF_SV_EXCESS] :
                    (op == ICF_OP_BRANCH_EXCESS) ? 1'b0 : excess_flag_ff; // see [R7]
  wire nxt_sat = is_load ? load_word[ICF_SV_SAT] :
                 (op == ICF_OP_SAT_ON)  ? 1'b1 :
                 (op == ICF_OP_SAT_OFF) ? 1'b0 : saturate_enable_ff; // see [R8] see [R2]

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ptr_select_ff       <= 1'b0;
      page_bit_ff         <= 1'b0;
      irq_global_block_ff <= 1'b1; // see [R3]
      excess_flag_ff      <= 1'b0; // see [R7]
      saturate_enable_ff  <= 1'b0;
    end
    else
    begin
      // save flags falls through with all bits held
      ptr_select_ff       <= nxt_ptr; // see [R10]
      page_bit_ff         <= nxt_page;
      irq_global_block_ff <= nxt_block;
      excess_flag_ff      <= nxt_excess;
      saturate_enable_ff  <= nxt_sat;
    end
  end

  assign ptr_select       = ptr_select_ff;
  assign page_bit         = page_bit_ff;
  assign irq_global_block = irq_global_block_ff;
  assign excess_flag      = excess_flag_ff;
  assign saturate_enable  = saturate_enable_ff;

  ////////////////////////////////////////////////////////////////////////////
  // save image and addressing
  logic [15:0] nxt_saved;
  logic [15:0] saved_ff;
  always_comb
  begin
    nxt_saved                = ICF_SV_ONES; // see [R1]
    nxt_saved[ICF_SV_EXCESS] = excess_flag_ff;
    nxt_saved[ICF_SV_SAT]    = saturate_enable_ff;
    nxt_saved[ICF_SV_BLOCK]  = irq_global_block_ff;
    nxt_saved[ICF_SV_PTR]    = ptr_select_ff;
    nxt_saved[ICF_SV_ZERO]   = 1'b0;
    nxt_saved[ICF_SV_PAGE]   = page_bit_ff;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      saved_ff <= 16'h0000;
    else
      saved_ff <= nxt_saved;
  end
  assign saved_flags = saved_ff;

  icf_flags_if u_flags ();
  assign u_flags.ptr_select = ptr_select_ff;
  assign u_flags.page_bit   = page_bit_ff;

  wire save_direct = (op == ICF_OP_SAVE_FLAGS) && !indirect; // see [R9]
  icf_addr_form u_addr (
    .flags        (u_flags),
    .instr_low    (instr_low),
    .indirect     (indirect),
    .save_direct  (save_direct),
    .aux_ptr_zero (aux_ptr_zero),
    .aux_ptr_one  (aux_ptr_one),
    .data_addr    (data_addr)
  ); // see [R6] see [R9] see [R5]

  ////////////////////////////////////////////////////////////////////////////
  // accumulator saturation
  wire [31:0] sat_val = acc_overflow_neg ? 32'h80000000 : 32'h7fffffff;
  wire [31:0] nxt_acc = (acc_overflow && saturate_enable_ff) ? sat_val : acc_raw; // see [R8]
  logic [31:0] acc_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      acc_ff <= 32'h00000000;
    else
      acc_ff <= nxt_acc;
  end
  assign acc_result = acc_ff;
endmodule

// ---- rtl/icf_pkg.sv ----
// constants and types for the interrupt and cpu flag block
// assumes a 16-bit processor core with an i/o bank/port register access
package icf_pkg;
  localparam int          ICF_W          = 16;
  localparam logic [3:0]  ICF_BANK_IRQ   = 4'h0;
  localparam logic [2:0]  ICF_PORT_PEND  = 3'h4;
  localparam logic [2:0]  ICF_PORT_MASK  = 3'h5;
  localparam logic [2:0]  ICF_PORT_CLR   = 3'h6;
  localparam logic [15:0] ICF_PEND_RST   = 16'h0000;
  localparam logic [15:0] ICF_MASK_RST   = 16'hffff;
  localparam int          ICF_NMI_BIT    = 15;
  localparam int          ICF_EXT_BIT    = 14;
  localparam int          ICF_RSVD_BIT   = 13;
  localparam int          ICF_SV_EXCESS  = 15;
  localparam int          ICF_SV_SAT     = 14;
  localparam int          ICF_SV_BLOCK   = 13;
  localparam int          ICF_SV_PTR     = 8;
  localparam int          ICF_SV_ZERO    = 1;
  localparam int          ICF_SV_PAGE    = 0;
  localparam logic [15:0] ICF_SV_ONES    = 16'h1efc;
  localparam logic [11:0] ICF_VECTOR     = 12'h002;
  localparam logic        ICF_SAVE_PAGE  = 1'b1;
  typedef enum logic [3:0] {
    ICF_OP_NONE, ICF_OP_BLOCK, ICF_OP_UNBLOCK, ICF_OP_LOAD_FLAGS, ICF_OP_SAVE_FLAGS,
    ICF_OP_LOAD_PTR, ICF_OP_MODIFY_PTR, ICF_OP_INDIRECT, ICF_OP_LOAD_PAGE,
    ICF_OP_LOAD_PAGE_CONST, ICF_OP_BRANCH_EXCESS, ICF_OP_SAT_ON, ICF_OP_SAT_OFF
  } icf_op_e;
endpackage

// ---- rtl/icf_flags_if.sv ----
// status bits passed between the top and the address former
// assumes a single clock domain
`timescale 1ns/1ps
interface icf_flags_if;
  logic ptr_select;
  logic page_bit;
  modport owner (output ptr_select, output page_bit);
  modport user  (input  ptr_select, input  page_bit);
endinterface

// ---- rtl/icf_edge_sync.sv ----
// two-flop synchroniser with falling edge pulse
// assumes an asynchronous pin input, idle high
`timescale 1ns/1ps
module icf_edge_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // flops reset low: a pin held low through reset and raised later gives no event
  assign fall = s3_ff & ~s2_ff;
endmodule

// ---- rtl/icf_addr_form.sv ----
// direct and indirect data address former
// assumes aux pointers come from the core register file
`timescale 1ns/1ps
module icf_addr_form (
  icf_flags_if.user  flags,
  input  wire logic [6:0]  instr_low,
  input  wire logic        indirect,
  input  wire logic        save_direct,
  input  wire logic [7:0]  aux_ptr_zero,
  input  wire logic [7:0]  aux_ptr_one,
  output logic      [7:0]  data_addr
);
  import icf_pkg::*;
  wire       page_used = save_direct ? ICF_SAVE_PAGE : flags.page_bit;
  wire [7:0] direct_a  = {page_used, instr_low};
  wire [7:0] ind_a     = flags.ptr_select ? aux_ptr_one : aux_ptr_zero;
  assign data_addr = indirect ? ind_a : direct_a;
endmodule

// ---- dv/icf_assertions.sv ----
// port assertions for the interrupt and cpu flag block
// assumes a bind onto icf_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
module icf_checker
  import icf_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_b,
  input wire icf_pkg::icf_op_e op,
  input wire logic [15:0]      load_word,
  input wire logic [6:0]       instr_low,
  input wire logic             indirect,
  input wire logic [7:0]       aux_ptr_zero,
  input wire logic [7:0]       aux_ptr_one,
  input wire logic             acc_overflow,
  input wire logic             acc_overflow_neg,
  input wire logic             irq_accept,
  input wire logic             take_irq,
  input wire logic             cpu_irq_request,
  input wire logic             nmi_request,
  input wire logic [11:0]      vector_addr,
  input wire logic [15:0]      saved_flags,
  input wire logic [7:0]       data_addr,
  input wire logic [31:0]      acc_result,
  input wire logic             ptr_select,
  input wire logic             page_bit,
  input wire logic             irq_global_block,
  input wire logic             excess_flag,
  input wire logic             saturate_enable
);
  logic [15:0] lw_ff;
  logic [15:0] img_ff;
  // one-cycle copies so the checks need no part-selects of $past
  always_ff @(posedge clk)
  begin
    lw_ff  <= load_word;
    img_ff <= {excess_flag, saturate_enable, irq_global_block, 4'hf, ptr_select, 6'h3f,
               1'h0, page_bit};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  a_reset_status: assert property (
    $rose(rst_b) |-> irq_global_block && !excess_flag)
    else $error("status bits wrong after reset");
  a_block_set: assert property (
    op == ICF_OP_BLOCK |=> irq_global_block)
    else $error("block op did not set block bit");
  a_unblock_clear: assert property (
    op == ICF_OP_UNBLOCK && !(irq_accept && take_irq) |=> !irq_global_block)
    else $error("unblock op did not clear block bit");
  a_block_hold: assert property (
    !(op inside {ICF_OP_BLOCK, ICF_OP_UNBLOCK}) && !(irq_accept && take_irq)
    |=> $stable(irq_global_block))
    else $error("block bit changed without cause");
  a_accept_blocks: assert property (
    irq_accept && take_irq |=> irq_global_block)
    else $error("taken interrupt left block bit clear");
  a_accept_drops: assert property (
    irq_accept && take_irq && !nmi_request |=> !cpu_irq_request)
    else $error("request still up after the cpu took it");
  a_take_gate: assert property (
    take_irq == (nmi_request || (cpu_irq_request && !irq_global_block)))
    else $error("take does not follow request and block");
  a_vector_word: assert property (
    take_irq |-> vector_addr == 12'h002)
    else $error("vector not word two");
  a_load_flags: assert property (
    op == ICF_OP_LOAD_FLAGS && !acc_overflow |=>
    {excess_flag, saturate_enable, ptr_select, page_bit}
    == {lw_ff[15], lw_ff[14], lw_ff[8], lw_ff[0]})
    else $error("load flags result wrong");
  a_save_image: assert property (
    $past(rst_b) |-> saved_flags == img_ff)
    else $error("saved flag word layout wrong");
  a_save_keeps: assert property (
    op == ICF_OP_SAVE_FLAGS && !acc_overflow && !irq_accept
    |=> $stable({excess_flag, saturate_enable, irq_global_block, ptr_select, page_bit}))
    else $error("save flags changed status");
  a_data_addr: assert property (
    data_addr == (indirect ? (ptr_select ? aux_ptr_one : aux_ptr_zero)
    : {(op == ICF_OP_SAVE_FLAGS) ? 1'h1 : page_bit, instr_low}))
    else $error("data address wrong");
  a_saturate: assert property (
    acc_overflow && saturate_enable |=> acc_result ==
    ($past(acc_overflow_neg) ? 32'h8000_0000 : 32'h7fff_ffff))
    else $error("saturated result wrong");
endmodule

// ---- dv/icf_cpu_model.sv ----
// core sequencer stand-in: raises irq_accept lat+1 cycles after take_irq rises
// assumes take_irq from icf_top; en lets the bench stall the core
`timescale 1ns/1ps
module icf_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       en,
  input  wire logic [3:0] lat,
  input  wire logic       take_irq,
  output logic            irq_accept
);
  logic [3:0] wait_ff;
  // one pulse per request: drops at once so no double entry
  always_ff @(posedge clk)
  begin
    if (!rst_b || !en || !take_irq || irq_accept)
    begin
      wait_ff    <= 4'h0;
      irq_accept <= 1'h0;
    end
    else if (wait_ff == lat)
      irq_accept <= 1'h1;
    else
      wait_ff    <= wait_ff + 4'h1;
  end
endmodule

// ---- dv/icf_tb_top.sv ----
// directed bench for the interrupt and cpu flag block
// assumes icf_pkg, icf_top, icf_cpu_model and icf_checker compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g));
module icf_tb_top;
  import icf_pkg::*;
  logic        clk, rst_b, nonmask_irq_pin, external_irq_pin, op_ptr_value, op_page_value;
  logic        indirect, acc_overflow, acc_overflow_neg, irq_accept, io_wr, io_rd, en;
  logic        io_hit, cpu_irq_request, nmi_request, take_irq, ptr_select, page_bit;
  logic        irq_global_block, excess_flag, saturate_enable;
  icf_op_e     op;
  icf_op_e     t_op [13];
  logic [4:0]  t_exp [13];
  logic [15:0] t_word [13];
  logic [3:0]  io_bank, lat;
  logic [2:0]  io_port;
  logic [6:0]  instr_low;
  logic [7:0]  aux_ptr_zero, aux_ptr_one, data_addr;
  logic [11:0] vector_addr;
  logic [12:0] per, t_val;
  logic [15:0] load_word, io_wdata, io_rdata, saved_flags;
  logic [16:0] rd;
  logic [31:0] acc_raw, acc_result;
  int          error_cnt, n_compared;
  logic [4:0]  st;
  assign st = {excess_flag, saturate_enable, irq_global_block, ptr_select, page_bit};
  icf_top i_icf_top (.*, .tmr3_serial_irq(per[12]), .cap3_irq(per[11]), .cap2_irq(per[10]),
    .cap1_irq(per[9]), .cap0_irq(per[8]), .cmp1_irq(per[7]), .cmp0_irq(per[6]),
    .tmr2_irq(per[5]), .tmr1_irq(per[4]), .rx_irq(per[3]), .tx_irq(per[2]),
    .watchdog_irq(per[1]), .bitio_irq(per[0]));
  icf_cpu_model i_icf_cpu_model (.clk(clk), .rst_b(rst_b), .en(en), .lat(lat),
    .take_irq(take_irq), .irq_accept(irq_accept));
  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // writes always go to the interrupt bank
  task automatic io_write(logic [2:0] p, logic [15:0] d);
    io_wr    = 1'h1;
    io_port  = p;
    io_wdata = d;
    tick();
    io_wr    = 1'h0;
    tick();
  endtask
  task automatic io_read(logic [3:0] b, logic [2:0] p);
    io_rd   = 1'h1;
    io_bank = b;
    io_port = p;
    tick();
    rd      = {io_hit, io_rdata};
    io_rd   = 1'h0;
    io_bank = 4'h0;
    tick();
  endtask
  task automatic do_op(icf_op_e o, logic v);
    op            = o;
    op_ptr_value  = v;
    op_page_value = v;
    indirect      = (o == ICF_OP_INDIRECT);
    tick();
    op            = ICF_OP_NONE;
    indirect      = 1'h0;
    tick();
  endtask
  task automatic ovf(logic neg, logic [31:0] raw, logic [31:0] e);
    acc_overflow     = 1'h1;
    acc_overflow_neg = neg;
    acc_raw          = raw;
    tick();
    acc_overflow     = 1'h0;
    `CHK("acc", e, acc_result)
    `CHK("excess", 1'h1, excess_flag)
    tick();
  endtask
  task automatic wait_accept();
    int k;
    k = 0;
    while (irq_accept !== 1'h1 && k < 40)
    begin
      tick();
      k++;
    end
    if (k == 40)
    begin
      error_cnt++;
      results();
    end
    tick();
  endtask
  ////////////////////////////////////////
  initial
  begin
    {clk, rst_b, nonmask_irq_pin, external_irq_pin, op_ptr_value, op_page_value} = '0;
    {indirect, acc_overflow, acc_overflow_neg, io_wr, io_rd, en, per} = '0;
    {io_bank, lat, io_port, load_word, io_wdata, acc_raw, error_cnt, n_compared} = '0;
    op           = ICF_OP_NONE;
    instr_low    = 7'h55;
    aux_ptr_zero = 8'h11;
    aux_ptr_one  = 8'h22;
    t_op   = '{ICF_OP_SAT_ON, ICF_OP_LOAD_PTR, ICF_OP_LOAD_PAGE, ICF_OP_UNBLOCK,
               ICF_OP_SAVE_FLAGS, ICF_OP_LOAD_FLAGS, ICF_OP_BRANCH_EXCESS, ICF_OP_BLOCK,
               ICF_OP_LOAD_FLAGS, ICF_OP_SAT_OFF, ICF_OP_MODIFY_PTR, ICF_OP_INDIRECT,
               ICF_OP_LOAD_PAGE_CONST};
    t_val  = 13'h0806;
    t_word = '{0: 16'h0000, 5: 16'h8000, 8: 16'h4101, default: 16'h0000};
    t_exp  = '{5'h0c, 5'h0e, 5'h0f, 5'h0b, 5'h0b, 5'h10, 5'h00, 5'h04, 5'h0f, 5'h07,
               5'h05, 5'h07, 5'h06};
    tick(6);
    rst_b            = 1'h1;
    nonmask_irq_pin  = 1'h1;
    external_irq_pin = 1'h1;
    tick(4);
    io_read(4'h0, 3'h4);
    `CHK("pending", 17'h1_0000, rd)
    io_read(4'h0, 3'h5);
    `CHK("mask", 17'h1_ffff, rd)
    io_read(4'h0, 3'h6);
    `CHK("clear_read", 17'h0, rd)
    io_read(4'h1, 3'h4);
    `CHK("other_bank", 17'h0, rd)
    for (int i = 0; i < 13; i++)
    begin
      load_word = t_word[i];
      do_op(t_op[i], t_val[i]);
      `CHK("status", t_exp[i], st)
      if (i == 4)
        `CHK("saved", 16'h5ffd, saved_flags)
    end
    // here ptr select is 1 and page bit 0
    `CHK("direct_addr", 8'h55, data_addr)
    indirect = 1'h1;
    tick();
    `CHK("ind_addr", 8'h22, data_addr)
    op       = ICF_OP_SAVE_FLAGS;
    indirect = 1'h0;
    tick();
    `CHK("save_addr", 8'hd5, data_addr)
    do_op(ICF_OP_SAT_ON, 1'h0);
    ovf(1'h1, 32'h0000_1234, 32'h8000_0000);
    do_op(ICF_OP_SAT_OFF, 1'h0);
    ovf(1'h0, 32'h1234_5678, 32'h1234_5678);
    for (int i = 0; i < 13; i++)
    begin
      per = 13'h1 << i;
      tick();
      per = '0;
      tick(2);
      `CHK("masked_req", 1'h0, cpu_irq_request)
      io_read(4'h0, 3'h4);
      `CHK("source_bit", {1'h1, 16'h1 << i}, rd)
      io_write(3'h6, 16'h1 << i);
    end
    en  = 1'h1;
    lat = 4'h3;
    per = 13'h0002;
    tick();
    per = '0;
    tick();
    io_write(3'h5, 16'hfffd);
    `CHK("unmasked_req", 1'h1, cpu_irq_request)
    `CHK("blocked_take", 1'h0, take_irq)
    do_op(ICF_OP_UNBLOCK, 1'h0);
    wait_accept();
    `CHK("vector", 12'h002, vector_addr)
    `CHK("block_on_take", 1'h1, irq_global_block)
    `CHK("req_on_take", 1'h0, cpu_irq_request)
    io_write(3'h6, 16'h0000);
    io_read(4'h0, 3'h4);
    `CHK("zero_clear", 17'h1_0002, rd)
    io_write(3'h6, 16'h0002);
    `CHK("req_cleared", 1'h0, cpu_irq_request)
    do_op(ICF_OP_UNBLOCK, 1'h0);
    do_op(ICF_OP_BLOCK, 1'h0);
    io_write(3'h5, 16'hffff);
    lat             = 4'h0;
    nonmask_irq_pin = 1'h0;
    wait_accept();
    `CHK("nmi_req", 1'h0, nmi_request)
    io_read(4'h0, 3'h4);
    `CHK("nmi_done", 17'h1_0000, rd)
    nonmask_irq_pin  = 1'h1;
    external_irq_pin = 1'h0;
    tick(6);
    io_read(4'h0, 3'h4);
    `CHK("ext_pin", 17'h1_4000, rd)
    io_write(3'h6, 16'h4000);
    results();
  end
endmodule
bind icf_top icf_checker i_icf_checker (.*);
